// *** common/hmc_defs.svh ***
// Summary of operation
// - Each check bit makes its three information bits plus itself even.
// - Decode recomputes check bits; syndrome zero passes information unchanged.
// - Syndrome 001 flags check bit low only; information untouched.
// - Syndrome 010 flags check bit mid only; information untouched.
// - Syndrome 100 flags check bit high only; information untouched.
// - Syndrome 011 inverts information bit two.
// - Syndrome 101 inverts information bit one.
// - Syndrome 110 inverts information bit zero.
// - Syndrome 111 inverts information bit three.
// - Any single flipped codeword bit is recovered correctly.
// - Stored byte holds one seven-bit codeword plus one error flag bit.
// - Decoder acts as 128-entry lookup giving corrected information and syndrome.
`ifndef HMC_DEFS_SVH
`define HMC_DEFS_SVH

`define HMC_INFO_W     4
`define HMC_CHECK_W    3
`define HMC_CW_W       7
`define HMC_FLAG_POS   7
`define HMC_LUT_DEPTH  128
`define HMC_LATENCY    1

`define HMC_SYN_NONE   3'h0
`define HMC_SYN_CLOW   3'h1
`define HMC_SYN_CMID   3'h2
`define HMC_SYN_INFO2  3'h3
`define HMC_SYN_CHIGH  3'h4
`define HMC_SYN_INFO1  3'h5
`define HMC_SYN_INFO0  3'h6
`define HMC_SYN_INFO3  3'h7

`define HMC_FLIP_INFO0 4'h1
`define HMC_FLIP_INFO1 4'h2
`define HMC_FLIP_INFO2 4'h4
`define HMC_FLIP_INFO3 4'h8

`endif

// *** common/hmc_pkg.sv ***
`default_nettype none
package hmc_pkg;

    typedef logic [3:0] hmc_info_t;
    typedef logic [2:0] hmc_syn_t;

    typedef struct packed {
        logic check_bit_high;
        logic check_bit_mid;
        logic check_bit_low;
        logic info_bit_three;
        logic info_bit_two;
        logic info_bit_one;
        logic info_bit_zero;
    } hmc_cw_s;

    // Byte as it sits in one half of a stored word
    typedef struct packed {
        logic    err_flag;
        hmc_cw_s cw;
    } hmc_byte_s;

    typedef struct packed {
        hmc_info_t info;
        hmc_syn_t  syndrome;
        logic      err;
        logic      flag_upd;
    } hmc_dec_s;

    // Check bits high, mid, low for four information bits
    function automatic hmc_syn_t hmc_check(input hmc_info_t i);
        hmc_check = {i[0] ^ i[1] ^ i[3], i[0] ^ i[2] ^ i[3], i[1] ^ i[2] ^ i[3]};
    endfunction

endpackage
`default_nettype wire

// *** rtl/hmc_codec.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hmc_defs.svh"
module hmc_codec (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               enc_valid,
    input  wire hmc_pkg::hmc_info_t enc_info,
    input  wire logic               enc_flag,
    output var  logic               enc_out_valid,
    output var  hmc_pkg::hmc_byte_s enc_out,
    input  wire logic               dec_valid,
    input  wire hmc_pkg::hmc_byte_s dec_in,
    output var  logic               dec_out_valid,
    output var  hmc_pkg::hmc_dec_s  dec_out,
    output var  logic               dec_err
);
    import hmc_pkg::*;

    // Syndrome-driven correction; equivalent to the full 128-entry table
    // but without storing it, since every entry follows from the syndrome
    function automatic hmc_dec_s hmc_correct(input hmc_cw_s cw);
        hmc_dec_s  d;
        hmc_info_t rx;
        hmc_info_t flip;
        rx   = {cw.info_bit_three, cw.info_bit_two, cw.info_bit_one, cw.info_bit_zero};
        flip = 4'h0;
        d.syndrome = hmc_check(rx) ^ {cw.check_bit_high, cw.check_bit_mid, cw.check_bit_low};
        case (d.syndrome)
            `HMC_SYN_INFO2: flip = `HMC_FLIP_INFO2;
            `HMC_SYN_INFO1: flip = `HMC_FLIP_INFO1;
            `HMC_SYN_INFO0: flip = `HMC_FLIP_INFO0;
            `HMC_SYN_INFO3: flip = `HMC_FLIP_INFO3;
            // Check-bit and clean syndromes leave data alone
            default:        flip = 4'h0;
        endcase
        d.info     = rx ^ flip;
        d.err      = (d.syndrome != `HMC_SYN_NONE);
        d.flag_upd = 1'b0;
        return d;
    endfunction

    wire hmc_syn_t  enc_check;
    wire hmc_byte_s enc_byte;
    wire hmc_dec_s  dec_raw;
    wire hmc_dec_s  dec_word;

    assign enc_check = hmc_check(enc_info);
    assign enc_byte  = {enc_flag, enc_check, enc_info};
    assign dec_raw   = hmc_correct(dec_in.cw);
    // Old flag kept sticky so a once-bad byte stays marked
    assign dec_word  = {dec_raw.info, dec_raw.syndrome, dec_raw.err, dec_in.err_flag | dec_raw.err};

    logic      enc_out_valid_ff;
    hmc_byte_s enc_out_ff;
    logic      dec_out_valid_ff;
    hmc_dec_s  dec_out_ff;
    logic      dec_err_ff;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            enc_out_valid_ff <= 1'b0;
            enc_out_ff       <= '0;
        end
        else
        begin
            enc_out_valid_ff <= enc_valid;
            if (enc_valid)
            begin
                enc_out_ff <= enc_byte;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dec_out_valid_ff <= 1'b0;
            dec_out_ff       <= '0;
            dec_err_ff       <= 1'b0;
        end
        else
        begin
            dec_out_valid_ff <= dec_valid;
            dec_err_ff       <= dec_valid & dec_word.err;
            if (dec_valid)
            begin
                dec_out_ff <= dec_word;
            end
        end
    end

    assign enc_out_valid = enc_out_valid_ff;
    assign enc_out       = enc_out_ff;
    assign dec_out_valid = dec_out_valid_ff;
    assign dec_out       = dec_out_ff;
    assign dec_err       = dec_err_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence enc_req;
        enc_valid ##1 enc_out_valid;
    endsequence

    sequence dec_req;
        dec_valid ##1 dec_out_valid;
    endsequence

    wire hmc_info_t out_cw_info;
    assign out_cw_info = {enc_out.cw.info_bit_three, enc_out.cw.info_bit_two,
                          enc_out.cw.info_bit_one, enc_out.cw.info_bit_zero};

    chk_enc_layout: assert property (enc_req |-> enc_out == {$past(enc_flag), hmc_check($past(enc_info)), $past(enc_info)})
        else $error("encoded byte wrong");
    chk_enc_even_sets: assert property (enc_out_valid |->
        !(enc_out.cw.check_bit_high ^ out_cw_info[0] ^ out_cw_info[1] ^ out_cw_info[3]) &&
        !(enc_out.cw.check_bit_mid ^ out_cw_info[0] ^ out_cw_info[2] ^ out_cw_info[3]) &&
        !(enc_out.cw.check_bit_low ^ out_cw_info[1] ^ out_cw_info[2] ^ out_cw_info[3]))
        else $error("check bit parity odd");
    chk_dec_clean_pass: assert property (dec_req ##0 dec_out.syndrome == `HMC_SYN_NONE |->
        dec_out.info == $past(dec_in[3:0]) && !dec_err)
        else $error("clean word altered");
    chk_syn_clow: assert property (dec_req ##0 dec_out.syndrome == `HMC_SYN_CLOW |-> dec_out.info == $past(dec_in[3:0]))
        else $error("low check error altered data");
    chk_syn_cmid: assert property (dec_req ##0 dec_out.syndrome == `HMC_SYN_CMID |-> dec_out.info == $past(dec_in[3:0]))
        else $error("mid check error altered data");
    chk_syn_chigh: assert property (dec_req ##0 dec_out.syndrome == `HMC_SYN_CHIGH |-> dec_out.info == $past(dec_in[3:0]))
        else $error("high check error altered data");
    chk_fix_info2: assert property (dec_req ##0 dec_out.syndrome == `HMC_SYN_INFO2 |->
        dec_out.info == ($past(dec_in[3:0]) ^ `HMC_FLIP_INFO2)) else $error("bit two not fixed");
    chk_fix_info1: assert property (dec_req ##0 dec_out.syndrome == `HMC_SYN_INFO1 |->
        dec_out.info == ($past(dec_in[3:0]) ^ `HMC_FLIP_INFO1)) else $error("bit one not fixed");
    chk_fix_info0: assert property (dec_req ##0 dec_out.syndrome == `HMC_SYN_INFO0 |->
        dec_out.info == ($past(dec_in[3:0]) ^ `HMC_FLIP_INFO0)) else $error("bit zero not fixed");
    chk_fix_info3: assert property (dec_req ##0 dec_out.syndrome == `HMC_SYN_INFO3 |->
        dec_out.info == ($past(dec_in[3:0]) ^ `HMC_FLIP_INFO3)) else $error("bit three not fixed");
    chk_single_fix: assert property (dec_req ##0 dec_out.err |->
        $countones({hmc_check(dec_out.info), dec_out.info} ^ $past(dec_in[6:0])) == 1)
        else $error("correction not one bit away");
    chk_flag_sticky: assert property (dec_req |-> dec_out.flag_upd == ($past(dec_in.err_flag) | dec_out.err))
        else $error("error flag update wrong");
    chk_syn_lookup: assert property (dec_req |-> dec_out.syndrome ==
        (hmc_check($past(dec_in[3:0])) ^ $past(dec_in[6:4]))) else $error("syndrome wrong");
    chk_err_pulse: assert property (dec_err == (dec_out_valid && dec_out.syndrome != `HMC_SYN_NONE))
        else $error("error indication mismatch");

    // Reference parity spelled out from the raw bits, apart from the shared
    // function, so a slip in that function cannot hide behind the checks above
    wire hmc_syn_t  ref_enc_check;
    wire hmc_syn_t  ref_dec_syn;
    wire hmc_info_t ref_fix;

    assign ref_enc_check = {enc_info[0] ^ enc_info[1] ^ enc_info[3],
                            enc_info[0] ^ enc_info[2] ^ enc_info[3],
                            enc_info[1] ^ enc_info[2] ^ enc_info[3]};
    assign ref_dec_syn   = {dec_in[6] ^ dec_in[0] ^ dec_in[1] ^ dec_in[3],
                            dec_in[5] ^ dec_in[0] ^ dec_in[2] ^ dec_in[3],
                            dec_in[4] ^ dec_in[1] ^ dec_in[2] ^ dec_in[3]};
    assign ref_fix       = {ref_dec_syn == `HMC_SYN_INFO3,
                            ref_dec_syn == `HMC_SYN_INFO2,
                            ref_dec_syn == `HMC_SYN_INFO1,
                            ref_dec_syn == `HMC_SYN_INFO0};

    sequence dec_clean;
        dec_valid && ref_dec_syn == `HMC_SYN_NONE ##1 dec_out_valid;
    endsequence

    sequence dec_faulty;
        dec_valid && ref_dec_syn != `HMC_SYN_NONE ##1 dec_out_valid;
    endsequence

    // Worked case: info 1000 stored, information bit three then worn out
    sequence dec_worn_top;
        dec_valid && dec_in.cw == 7'h70 ##1 dec_out_valid;
    endsequence

    chk_enc_ref_bits: assert property (enc_req |->
        {enc_out.cw.check_bit_high, enc_out.cw.check_bit_mid, enc_out.cw.check_bit_low} ==
        $past(ref_enc_check))
        else $error("check bits differ from reference");
    chk_enc_info_pass: assert property (enc_req |-> out_cw_info == $past(enc_info))
        else $error("information bits not passed through");
    chk_enc_flag_pos: assert property (enc_req |-> enc_out.err_flag == $past(enc_flag))
        else $error("flag bit misplaced");
    chk_syn_ref: assert property (dec_req |-> dec_out.syndrome == $past(ref_dec_syn))
        else $error("syndrome differs from reference");
    chk_fix_ref: assert property (dec_req |->
        dec_out.info == ($past(dec_in[3:0]) ^ $past(ref_fix)))
        else $error("correction differs from reference");
    chk_clean_quiet: assert property (dec_clean |-> !dec_err && !dec_out.err)
        else $error("error raised on clean word");
    chk_fault_raised: assert property (dec_faulty |->
        dec_err && dec_out.err && dec_out.flag_upd)
        else $error("error not raised on faulty word");
    chk_table_entry: assert property (dec_worn_top |->
        dec_out.info == 4'h8 && dec_out.syndrome == `HMC_SYN_INFO3 && dec_err)
        else $error("table entry decoded wrong");

    // Results stand until the next request; strobes last one cycle
    chk_enc_answer: assert property (enc_valid |=> enc_out_valid)
        else $error("encode request not answered");
    chk_enc_idle: assert property (!enc_valid |=>
        !enc_out_valid && $stable(enc_out))
        else $error("encoded byte moved without request");
    chk_dec_answer: assert property (dec_valid |=> dec_out_valid)
        else $error("decode request not answered");
    chk_dec_idle: assert property (!dec_valid |=>
        !dec_out_valid && !dec_err && $stable(dec_out))
        else $error("decoded result moved without request");

    // Default disable would mask the very edges this one watches
    chk_reset_clear: assert property (disable iff (1'b0) reset |=>
        !enc_out_valid && !dec_out_valid && !dec_err && enc_out == '0 && dec_out == '0)
        else $error("outputs not cleared by reset");

endmodule
`default_nettype wire

// *** verification/hmc_store_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module hmc_store_model (
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    output var  logic [15:0] rdata
);
    // Two coded bytes per word, each byte keeps its own sticky flag
    logic [15:0] mem [16];
    always_ff @(posedge clk)
    begin
        if (we)
            mem[addr] <= wdata;
    end
    assign rdata = mem[addr];
endmodule
`default_nettype wire

// *** verification/test_hamming_7_4_codec.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_hamming_7_4_codec;
    import hmc_pkg::*;
    logic      clk, reset, enc_valid, enc_flag, enc_out_valid, dec_valid, dec_out_valid, dec_err, we;
    hmc_info_t enc_info;
    hmc_byte_s enc_out, dec_in;
    hmc_dec_s  dec_out;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata;
    int n_mismatch = 0;
    int n_tests = 0;

    hmc_codec DUT (.clk(clk), .reset(reset), .enc_valid(enc_valid), .enc_info(enc_info), .enc_flag(enc_flag),
        .enc_out_valid(enc_out_valid), .enc_out(enc_out), .dec_valid(dec_valid), .dec_in(dec_in),
        .dec_out_valid(dec_out_valid), .dec_out(dec_out), .dec_err(dec_err));
    hmc_store_model store (.clk(clk), .we(we), .addr(addr), .wdata(wdata), .rdata(rdata));

    always #12.5 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Expected byte worked out independently of the design package
    function automatic logic [7:0] code_of(input logic f, input logic [3:0] i);
        return {f, i[0] ^ i[1] ^ i[3], i[0] ^ i[2] ^ i[3], i[1] ^ i[2] ^ i[3], i};
    endfunction

    task automatic decode(input logic [7:0] b, input logic [3:0] info, input logic [2:0] syn);
        logic e;
        e = |syn;
        dec_valid = 1'b1;
        dec_in = b;
        @(negedge clk);
        check("dec_out_valid", 16'(dec_out_valid), 16'h1);
        check("dec_out", 16'(dec_out), 16'({info, syn, e, b[7] | e}));
        check("dec_err", 16'(dec_err), 16'(e));
    endtask

    // Valid stays high across a run of decodes; dropped here once the run ends
    task automatic dec_idle;
        dec_valid = 1'b0;
        @(negedge clk);
        check("dec_out_valid_low", 16'(dec_out_valid), 16'h0);
        check("dec_err_low", 16'(dec_err), 16'h0);
    endtask

    // Back-to-back requests: valid held high across all sixteen values
    task automatic t_encode;
        for (int i = 0; i < 16; i++)
        begin
            enc_valid = 1'b1;
            enc_info = i[3:0];
            enc_flag = i[1];
            @(negedge clk);
            check("enc_out_valid", 16'(enc_out_valid), 16'h1);
            check("enc_out", 16'(enc_out), 16'(code_of(i[1], i[3:0])));
        end
        enc_valid = 1'b0;
        @(negedge clk);
        check("enc_out_valid_low", 16'(enc_out_valid), 16'h0);
        $display("encode test done");
    endtask

    // Every single flip of every codeword, plus the clean word
    task automatic t_single;
        logic [7:0] cw;
        logic [2:0] syn [7];
        syn = '{3'h6, 3'h5, 3'h3, 3'h7, 3'h1, 3'h2, 3'h4};
        for (int i = 0; i < 16; i++)
        begin
            cw = code_of(i[0], i[3:0]);
            decode(cw, i[3:0], 3'h0);
            for (int k = 0; k < 7; k++)
                decode(cw ^ (8'h01 << k), i[3:0], syn[k]);
        end
        dec_idle;
        $display("single error test done");
    endtask

    task automatic t_store;
        logic [7:0] lo, hi;
        enc_valid = 1'b1;
        enc_info = 4'h5;
        enc_flag = 1'b0;
        @(negedge clk);
        lo = enc_out;
        enc_info = 4'hA;
        enc_flag = 1'b1;
        @(negedge clk);
        hi = enc_out;
        enc_valid = 1'b0;
        we = 1'b1;
        addr = 4'h3;
        wdata = {hi, lo};
        @(negedge clk);
        we = 1'b0;
        decode(rdata[7:0], 4'h5, 3'h0);
        decode(rdata[15:8] ^ 8'h04, 4'hA, 3'h3);
        dec_idle;
        $display("stored word test done");
    endtask

    // Reset in mid-run must clear results held from earlier work
    task automatic t_reset;
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        check("enc_out_after_reset", 16'(enc_out), 16'h0);
        check("dec_out_after_reset", 16'(dec_out), 16'h0);
        check("valid_after_reset", 16'({enc_out_valid, dec_out_valid, dec_err}), 16'h0);
        decode(8'h70, 4'h8, 3'h7);
        dec_idle;
        $display("reset test done");
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        {enc_valid, enc_flag, dec_valid, we} = 4'h0;
        enc_info = 4'h0;
        dec_in = 8'h00;
        addr = 4'h0;
        wdata = 16'h0000;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        check("dec_out_reset", 16'(dec_out), 16'h0);
        t_encode;
        t_single;
        t_store;
        t_reset;
        tally_and_finish;
    end

    // Whole run needs about 160 cycles; far margin before giving up
    initial
    begin
        #(25 * 2000);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
